// ==== hdl/microprogram_sequencer.sv ====
// Program sequencer with gated system clock and an APB register port.
// Assumes all pin inputs are synchronous to clk_sys; the crystal input is
// sampled as a level and divided here, so it must be well below clk_sys/2.
`timescale 1ns/1ps
`include "seq_regs.svh"

module microprogram_sequencer
  import seq_pkg::*;
#(
  parameter logic [`ROM_DEPTH*`INSTR_W-1:0] ROM_IMAGE = '0
) (
  // Clock, reset and clock enable
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                ce,
  // Crystal and address sources
  input  wire logic                xtalIn,
  input  wire logic                addressLoadEnableN,
  input  wire logic [`ADDR_W-1:0]  startAddr,
  input  wire logic [`ADDR_W-1:0]  orBits,
  input  wire logic                addrClearN,
  // Clock mode controls
  input  wire logic                stepModeSelectN,
  input  wire logic                runModeSelectN,
  input  wire logic                runTrigger,
  input  wire logic                stopArm,
  input  wire logic                setPulse,
  // Instruction bus and clocks
  output logic [`INSTR_W-1:0]      instrBus,
  output logic [`ADDR_W-1:0]       progAddr,
  output logic                     seqLoadEn,
  output logic                     sysClkOut,
  output logic                     gatedClkOut,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr
);

  logic      rstMeta;
  logic      rstSync;
  seqState_s state_reg;
  seqState_s state_next;
  logic      xtalRise;
  logic      sysTick;
  logic      sysFall;
  logic      runFall;
  logic      stopFall;
  logic      armFall;
  logic      setFall;
  logic      pass;
  logic      loadReq;
  logic      apbSetup;
  logic      apbWrite;
  logic [6:0] ctrlPulse;

  function automatic logic [`INSTR_W-1:0] romWord(input logic [`ADDR_W-1:0] a);
    romWord = ROM_IMAGE[int'(a)*`INSTR_W +: `INSTR_W];
  endfunction

  // Reset is released through two flip-flops to avoid a metastable release.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  always_comb begin
    state_next = state_reg;
    xtalRise   = xtalIn & ~state_reg.xtalPrev;
    sysTick    = xtalRise & ~state_reg.sysClk;
    sysFall    = xtalRise & state_reg.sysClk;
    runFall    = state_reg.runPrev & ~runTrigger;
    apbSetup   = psel & ~penable;
    apbWrite   = psel & penable & state_reg.pready & pwrite;
    ctrlPulse  = (apbWrite && paddr == `OFF_CTRL) ? pwdata[6:0] : 7'h00;
    stopFall   = (state_reg.stopPrev & ~stopArm) | ctrlPulse[`CTRL_STOP];
    armFall    = stopFall | ctrlPulse[`CTRL_ARM];
    setFall    = (state_reg.setPrev & ~setPulse) | ctrlPulse[`CTRL_SET];
    loadReq    = ~addressLoadEnableN | state_reg.swLoad;
    pass       = 1'b0;
    if (ce) begin
      state_next.xtalPrev = xtalIn;
      state_next.runPrev  = runTrigger;
      state_next.stopPrev = stopArm;
      state_next.setPrev  = setPulse;
      if (xtalRise) begin
        state_next.sysClk = ~state_reg.sysClk;
      end

      // Run select is applied first so a simultaneous step select wins.
      if (!runModeSelectN || ctrlPulse[`CTRL_RUN_SEL]) begin
        state_next.mode = RUN_MODE;
      end
      if (!stepModeSelectN || ctrlPulse[`CTRL_STEP_SEL]) begin
        state_next.mode = STEP_MODE;
      end

      if (stopFall || state_next.mode == STEP_MODE) begin
        state_next.runOn = 1'b0;
      end else if (runFall || ctrlPulse[`CTRL_RUN]) begin
        state_next.runOn = 1'b1;
      end

      if (state_reg.mode == RUN_MODE) begin
        pass = sysTick & state_reg.runOn;
      end else begin
        pass = sysTick & (state_reg.step == STEP_SET);
      end

      case (state_reg.step)
        STEP_IDLE: begin
          if (armFall) begin
            state_next.step = STEP_ARMED;
          end
        end
        STEP_ARMED: begin
          if (setFall) begin
            state_next.step = STEP_SET;
          end
        end
        STEP_SET: begin
          if (pass) begin
            state_next.step = STEP_IDLE;
          end
        end
        default: begin
          state_next.step = STEP_IDLE;
        end
      endcase
      if (state_next.mode != STEP_MODE) begin
        state_next.step = STEP_IDLE;
      end

      if (pass) begin
        state_next.gatedClk = 1'b1;
      end else if (sysFall) begin
        state_next.gatedClk = 1'b0;
      end

      // A software load request raised in the consuming cycle survives.
      if (pass && loadReq) begin
        state_next.swLoad = 1'b0;
      end
      if (ctrlPulse[`CTRL_LOAD]) begin
        state_next.swLoad = 1'b1;
      end

      if (!addrClearN) begin
        state_next.addr = '0;
      end else if (pass) begin
        if (loadReq) begin
          state_next.addr = state_reg.swLoad ? state_reg.startSw : startAddr;
        end else if (state_reg.seqLoad) begin
          state_next.seqWord = state_reg.instr;
          if (state_reg.instr[`INSTR_JUMP_BIT]) begin
            state_next.addr = state_reg.instr[`ADDR_W-1:0];
          end else if (state_reg.instr[`INSTR_OR_BIT]) begin
            state_next.addr = state_reg.addr | orBits;
          end else begin
            state_next.addr = state_reg.addr + 8'h01;
          end
        end else begin
          state_next.addr = state_reg.addr + 8'h01;
        end
      end

      state_next.instr   = romWord(state_next.addr);
      state_next.seqLoad = ~state_next.instr[`INSTR_TOP_BIT];

      if (apbWrite && paddr == `OFF_START) begin
        state_next.startSw = pwdata[`ADDR_W-1:0];
      end
      state_next.pready  = apbSetup;
      state_next.pslverr = 1'b0;
      state_next.prdata  = 32'h0000_0000;
      if (apbSetup) begin
        case (paddr)
          `OFF_CTRL: begin
            state_next.prdata = 32'h0000_0000;
          end
          `OFF_START: begin
            state_next.prdata[`ADDR_W-1:0] = state_reg.startSw;
          end
          `OFF_STATUS: begin
            state_next.prdata[`ADDR_W-1:0] = state_reg.addr;
            state_next.prdata[`ST_MODE]    = (state_reg.mode == STEP_MODE);
            state_next.prdata[`ST_RUN_ON]  = state_reg.runOn;
            state_next.prdata[`ST_STEP_LSB +: 2] = state_reg.step;
            state_next.prdata[`ST_GATED]   = state_reg.gatedClk;
          end
          `OFF_INSTR: begin
            state_next.prdata[`INSTR_W-1:0] = state_reg.instr;
          end
          `OFF_SEQWORD: begin
            state_next.prdata[`INSTR_W-1:0] = state_reg.seqWord;
          end
          default: begin
            state_next.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      state_reg         <= '0;
      state_reg.mode    <= RUN_MODE;
      state_reg.step    <= STEP_IDLE;
      state_reg.xtalPrev <= 1'b1;
      state_reg.runPrev <= 1'b1;
      state_reg.stopPrev <= 1'b1;
      state_reg.setPrev <= 1'b1;
      state_reg.instr   <= ROM_IMAGE[`INSTR_W-1:0];
      state_reg.seqLoad <= ~ROM_IMAGE[`INSTR_TOP_BIT];
    end else begin
      state_reg <= state_next;
    end
  end

  assign instrBus    = state_reg.instr;
  assign progAddr    = state_reg.addr;
  assign seqLoadEn   = state_reg.seqLoad;
  assign sysClkOut   = state_reg.sysClk;
  assign gatedClkOut = state_reg.gatedClk;
  assign prdata      = state_reg.prdata;
  assign pready      = state_reg.pready;
  assign pslverr     = state_reg.pslverr;

  a_instr_from_rom: assert property (@(posedge clk_sys) disable iff (!rstSync)
    instrBus == romWord(progAddr)) else $error("Instruction bus does not match ROM.");

  a_seq_load_flag: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && !loadReq && addrClearN && seqLoadEn |=> state_reg.seqWord == $past(instrBus))
    else $error("Sequencer word not captured.");

  a_clear_wins: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && !addrClearN |=> progAddr == 8'h00) else $error("Address not cleared.");

  a_load_start: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && addrClearN && !addressLoadEnableN && !state_reg.swLoad
    |=> progAddr == $past(startAddr)) else $error("Start address not loaded.");

  a_addr_increment: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && addrClearN && !loadReq && !seqLoadEn
    |=> progAddr == $past(progAddr) + 8'h01) else $error("Address did not step by one.");

  a_jump_target: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && addrClearN && !loadReq && seqLoadEn && instrBus[`INSTR_JUMP_BIT]
    |=> progAddr == $past(instrBus[7:0])) else $error("Jump target not taken.");

  a_or_bits: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && addrClearN && !loadReq && seqLoadEn && !instrBus[`INSTR_JUMP_BIT]
    && instrBus[`INSTR_OR_BIT] |=> progAddr == ($past(progAddr) | $past(orBits)))
    else $error("Address not OR'ed with external bits.");

  a_xtal_divide: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && xtalIn && !state_reg.xtalPrev |=> sysClkOut != $past(sysClkOut))
    else $error("System clock did not toggle on crystal edge.");

  // In step mode the stop pin doubles as arm, so only run mode is held to this.
  a_stop_halts: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && stopFall && state_reg.mode == RUN_MODE |=> !state_reg.runOn ##1 !pass)
    else $error("Stop did not halt clock.");

  a_single_step: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && state_reg.mode == STEP_MODE |=> state_reg.step != STEP_SET)
    else $error("Second step pulse allowed without rearm.");

  // Mode selection and the run gate.
  a_run_select: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && !runModeSelectN && stepModeSelectN && !ctrlPulse[`CTRL_STEP_SEL]
    |=> state_reg.mode == RUN_MODE) else $error("Run mode not selected.");

  a_step_select: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && !stepModeSelectN |=> state_reg.mode == STEP_MODE)
    else $error("Step mode not selected.");

  a_run_starts: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && runFall && !stopFall && state_next.mode == RUN_MODE |=> state_reg.runOn)
    else $error("Run trigger did not open the gate.");

  a_run_gate: assert property (@(posedge clk_sys) disable iff (!rstSync)
    state_reg.mode == RUN_MODE && !state_reg.runOn |-> !pass)
    else $error("Pulse passed with the run gate closed.");

  // Selecting step mode must never leave the free-running gate open.
  a_step_mode_gate: assert property (@(posedge clk_sys) disable iff (!rstSync)
    state_reg.mode == STEP_MODE |-> !state_reg.runOn)
    else $error("Run gate open in step mode.");

  a_step_once: assert property (@(posedge clk_sys) disable iff (!rstSync)
    state_reg.mode == STEP_MODE && state_reg.step != STEP_SET |-> !pass)
    else $error("Step pulse passed without arm and set.");

  a_run_no_step: assert property (@(posedge clk_sys) disable iff (!rstSync)
    state_reg.mode == RUN_MODE |-> state_reg.step == STEP_IDLE)
    else $error("Step sequencer active in run mode.");

  // Clock division and the shape of the gated pulse.
  a_sysclk_hold: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && !xtalRise |=> $stable(sysClkOut))
    else $error("System clock moved without a crystal edge.");

  a_gate_pulse: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass |=> gatedClkOut) else $error("Gated clock did not rise on a pass.");

  a_gate_follows: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && sysFall |=> !gatedClkOut)
    else $error("Gated clock did not fall with the system clock.");

  // Address sources: nothing but clear may move the address between pulses.
  a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && !pass && addrClearN |=> $stable(progAddr))
    else $error("Address moved without a clock pulse.");

  a_sw_load_first: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pass && addrClearN && state_reg.swLoad
    |=> progAddr == $past(state_reg.startSw))
    else $error("Software start address not loaded first.");

  a_seq_level: assert property (@(posedge clk_sys) disable iff (!rstSync)
    seqLoadEn == !instrBus[`INSTR_TOP_BIT])
    else $error("Load enable does not follow the top instruction bit.");

  // Register port: one wait-free access cycle, and a clean error on holes.
  a_apb_answer: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && psel && !penable |=> pready) else $error("No ready after setup.");

  a_apb_drop: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && pready && penable |=> !pready) else $error("Ready held past the access.");

  a_apb_hole: assert property (@(posedge clk_sys) disable iff (!rstSync)
    ce && psel && !penable && paddr > `OFF_SEQWORD |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped address not refused.");

endmodule

// ==== hdl/seq_regs.svh ====
// Constants of the program sequencer: widths, register offsets and fields.
// Assumes inclusion by bare name from the sequencer package and module.
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

`define ADDR_W          8
`define INSTR_W         16
`define ROM_DEPTH       256
`define INSTR_TOP_BIT   15
`define INSTR_JUMP_BIT  14
`define INSTR_OR_BIT    13
`define CLK_PERIOD_NS   5
`define XTAL_DIVIDE     2

`define OFF_CTRL        8'h00
`define OFF_START       8'h04
`define OFF_STATUS      8'h08
`define OFF_INSTR       8'h0c
`define OFF_SEQWORD     8'h10

`define CTRL_LOAD       0
`define CTRL_RUN        1
`define CTRL_STOP       2
`define CTRL_ARM        3
`define CTRL_SET        4
`define CTRL_STEP_SEL   5
`define CTRL_RUN_SEL    6

`define ST_MODE         8
`define ST_RUN_ON       9
`define ST_STEP_LSB     10
`define ST_GATED        12

`endif

// ==== hdl/seq_pkg.sv ====
// Types shared by the program sequencer: clock modes and the state record.
// Assumes seq_regs.svh is on the include path.
`include "seq_regs.svh"

package seq_pkg;

  typedef enum logic {
    RUN_MODE,
    STEP_MODE
  } clkMode_e;

  typedef enum logic [1:0] {
    STEP_IDLE,
    STEP_ARMED,
    STEP_SET
  } step_e;

  typedef struct packed {
    logic [`ADDR_W-1:0]  addr;
    logic [`INSTR_W-1:0] instr;
    logic [`INSTR_W-1:0] seqWord;
    logic                seqLoad;
    logic                xtalPrev;
    logic                sysClk;
    logic                gatedClk;
    clkMode_e            mode;
    step_e               step;
    logic                runOn;
    logic                runPrev;
    logic                stopPrev;
    logic                armPrev;
    logic                setPrev;
    logic [`ADDR_W-1:0]  startSw;
    logic                swLoad;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } seqState_s;

endpackage

// ==== verif/instr_decoder_model.sv ====
// Model of the boards that decode the sequencer's instruction bus.
// Assumes the word on the bus is settled before each gated clock rise.
`timescale 1ns/1ps

module instr_decoder_model (
  // Instruction bus from the sequencer
  input  wire logic [15:0] instrBus,
  input  wire logic        gatedClk,
  // Decoded board selects and the word the arithmetic board took
  output logic             aluSel,
  output logic             busSel,
  output logic [15:0]      aluWord
);
  assign aluSel = (instrBus[15:14] == 2'b10);
  assign busSel = (instrBus[15:14] == 2'b11);

  // Only words meant for the arithmetic board reach its latch.
  always @(posedge gatedClk) begin
    if (aluSel) begin
      aluWord <= instrBus;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the program sequencer: pin scenarios and APB access.
// Assumes the sequencer package and header are compiled before this file.
`timescale 1ns/1ps
`include "seq_regs.svh"

module testbench;
  localparam int XH = 10;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        xtalIn = 1'b0;
  logic        addressLoadEnableN = 1'b1;
  logic        addrClearN = 1'b1;
  logic        stepModeSelectN = 1'b1;
  logic        runModeSelectN = 1'b1;
  logic        runTrigger = 1'b1;
  logic        stopArm = 1'b1;
  logic        setPulse = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  startAddr = 8'h0e;
  logic [7:0]  orBits = 8'h40;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] instrBus;
  logic [7:0]  progAddr;
  logic        seqLoadEn, sysClkOut, gatedClkOut, pready, pslverr, aluSel, busSel;
  logic [31:0] prdata, rd;
  logic        err, gPrev = 1'b0;
  int          fail_count = 0, checks = 0, cyc = 0, xc = 0, rises = 0, n;

  function automatic logic [15:0] romW(input logic [7:0] a);
    case (a)
      8'h0f:   return 16'hc00f;
      8'h10:   return 16'h4020;
      8'h21:   return 16'h2000;
      default: return {8'h80, a};
    endcase
  endfunction

  function automatic logic [`ROM_DEPTH*`INSTR_W-1:0] mkRom();
    logic [`ROM_DEPTH*`INSTR_W-1:0] r;
    for (int i = 0; i < `ROM_DEPTH; i++) r[16*i+:16] = romW(8'(i));
    return r;
  endfunction

  microprogram_sequencer #(.ROM_IMAGE(mkRom())) microprogram_sequencer_i (
    .clk_sys, .nrst, .ce(1'b1), .xtalIn, .addressLoadEnableN, .startAddr, .orBits,
    .addrClearN, .stepModeSelectN, .runModeSelectN, .runTrigger, .stopArm, .setPulse,
    .instrBus, .progAddr, .seqLoadEn, .sysClkOut, .gatedClkOut, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  instr_decoder_model instr_decoder_model_i (
    .instrBus, .gatedClk(gatedClkOut), .aluSel, .busSel, .aluWord());

  always #2.5 clk_sys = ~clk_sys;

  // The crystal is a slow level here, so each of its rises is seen many clocks apart.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    gPrev <= gatedClkOut;
    if (gatedClkOut && !gPrev) rises <= rises + 1;
    xc <= (xc == XH - 1) ? 0 : xc + 1;
    if (xc == XH - 1) xtalIn <= ~xtalIn;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lowPulse(input int p);
    @(posedge clk_sys);
    case (p)
      0: runModeSelectN <= 1'b0;
      1: stepModeSelectN <= 1'b0;
      2: runTrigger <= 1'b0;
      3: stopArm <= 1'b0;
      default: setPulse <= 1'b0;
    endcase
    repeat (2) @(posedge clk_sys);
    {runModeSelectN, stepModeSelectN, runTrigger, stopArm, setPulse} <= 5'h1f;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic stepChk(input logic [7:0] a);
    int k;
    logic [15:0] w;
    k = rises;
    w = romW(a);
    for (int i = 0; i < 200 && rises == k; i++) @(posedge clk_sys);
    @(posedge clk_sys);
    chk(progAddr, a);
    chk(instrBus, w);
    chk(seqLoadEn, !w[15]);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(instrBus, romW(8'h00));
    apb(1'b0, `OFF_START, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFF_START, 32'h5a);
    apb(1'b1, `OFF_STATUS, 32'hfff);
    apb(1'b0, `OFF_START, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_INSTR, 32'h0);
    chk(rd, romW(8'h00));
    n = 0;
    while (sysClkOut !== 1'b0) @(posedge clk_sys);
    while (sysClkOut !== 1'b1) @(posedge clk_sys);
    while (sysClkOut === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n, 2 * XH);
    addressLoadEnableN <= 1'b0;
    lowPulse(0);
    lowPulse(2);
    stepChk(8'h0e);
    chk(aluSel, 1'b1);
    addressLoadEnableN <= 1'b1;
    stepChk(8'h0f);
    chk({busSel, aluSel}, 2'b10);
    stepChk(8'h10);
    stepChk(8'h20);
    stepChk(8'h21);
    stepChk(8'h61);
    addrClearN <= 1'b0;
    addressLoadEnableN <= 1'b0;
    startAddr <= 8'h10;
    repeat (3) @(posedge clk_sys);
    chk(progAddr, 8'h00);
    stepChk(8'h00);
    addrClearN <= 1'b1;
    stepChk(8'h10);
    stepChk(8'h10);
    addressLoadEnableN <= 1'b1;
    stepChk(8'h20);
    lowPulse(3);
    n = rises;
    rd = progAddr;
    repeat (120) @(posedge clk_sys);
    chk(rises, n);
    chk(progAddr, rd[7:0]);
    lowPulse(1);
    lowPulse(3);
    lowPulse(4);
    stepChk(8'h21);
    n = rises;
    repeat (120) @(posedge clk_sys);
    chk(rises, n);
    lowPulse(4);
    repeat (120) @(posedge clk_sys);
    chk(rises, n);
    lowPulse(3);
    lowPulse(4);
    stepChk(8'h61);
    finish_test();
  end
endmodule
